// [src/sac_defs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH
`define SAC_CON1_ADDR 8'hef
`define SAC_CON2_ADDR 8'hd8
`define SAC_CON3_ADDR 8'hf5
`define SAC_DATAL_ADDR 8'hd9
`define SAC_DATAH_ADDR 8'hda
`define SAC_DMAL_ADDR 8'hd2
`define SAC_DMAH_ADDR 8'hd3
`define SAC_DMAP_ADDR 8'hd4
`define SAC_OFSL_ADDR 8'hf1
`define SAC_OFSH_ADDR 8'hf2
`define SAC_GAINL_ADDR 8'hf3
`define SAC_GAINH_ADDR 8'hf4
`define SAC_CON1_RST 8'h40
`define SAC_CON2_RST 8'h00
`define SAC_BIT_PWR 7
`define SAC_BIT_EXTREF 6
`define SAC_BIT_CK_HI 5
`define SAC_BIT_CK_LO 4
`define SAC_BIT_AQ_HI 3
`define SAC_BIT_AQ_LO 2
`define SAC_BIT_T2C 1
`define SAC_BIT_EXC 0
`define SAC_BIT_DONE 7
`define SAC_BIT_DMA 6
`define SAC_BIT_CONT 5
`define SAC_BIT_SCONV 4
`define SAC_CONV_CLKS 5'h10
`define SAC_CAL_WORDS 2'h3
`define SAC_CAL_OFS_DEF 16'h0000
`define SAC_CAL_GAIN_DEF 16'h8000
`define SAC_CAL_RST 16'h0000
`define SAC_CON3_RST 8'h00
`define SAC_CAL_OFS_WORD 2'h0
`define SAC_CAL_GAIN_WORD 2'h1
`define SAC_CAL_OFS_LOAD 2'h1
`define SAC_CAL_GAIN_LOAD 2'h2
`define SAC_DIV_CODE0 6'h20
`define SAC_DIV_CODE1 6'h04
`define SAC_DIV_CODE2 6'h08
`define SAC_DIV_CODE3 6'h02
`define SAC_CHAN_HI 3
`define SAC_CHAN_LO 0
`endif

// [src/sac_pkg.sv]
// Types shared by the converter control front end
package sac_pkg;
   typedef enum logic [2:0] {
      SAC_CAL = 3'b000,
      SAC_IDLE = 3'b001,
      SAC_ACQ = 3'b011,
      SAC_CONV = 3'b010,
      SAC_DONE = 3'b110,
      SAC_DMA1 = 3'b111,
      SAC_DMA2 = 3'b101
   } sac_state_t;
endpackage : sac_pkg

// [src/sac_cal_if.sv]
// Calibration store access path between the control and the store
`timescale 1ns/10ps
`default_nettype none
interface sac_cal_if;
   logic [1:0] addr;
   logic [15:0] rdata;
   modport ctrl (output addr, input rdata);
   modport mem (input addr, output rdata);
endinterface : sac_cal_if
`default_nettype wire

// [src/sac_cal_rom.sv]
// Factory calibration store with registered read data
`timescale 1ns/10ps
`default_nettype none
module sac_cal_rom
   import sac_pkg::*;
(
   input wire logic sys_clk,
   sac_cal_if.mem cal
);
`include "sac_defs.svh"
   // Word 0 offset, word 1 gain, rest unused
   always_ff @(posedge sys_clk) begin
      unique case (cal.addr)
         `SAC_CAL_OFS_WORD: cal.rdata <= `SAC_CAL_OFS_DEF;
         `SAC_CAL_GAIN_WORD: cal.rdata <= `SAC_CAL_GAIN_DEF;
         default: cal.rdata <= 16'h0000;
      endcase
   end
endmodule : sac_cal_rom
`default_nettype wire

// [src/sac_ctrl.sv]
// Converter control: registers, triggers, sequencer, results and capture
`timescale 1ns/10ps
`default_nettype none
module sac_ctrl
   import sac_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWr,
   input wire logic sfrRd,
   input wire logic [7:0] sfrWdata,
   output logic [7:0] sfrRdata,
   input wire logic timerOverflow,
   input wire logic convertStartPin_n,
   input wire logic calWr,
   input wire logic calSelGain,
   input wire logic [15:0] calWdata,
   output logic converterPowerOn,
   output logic outsideReferenceSelect,
   output logic [3:0] channelSel,
   output logic sampleHold,
   output logic convertStrobe,
   input wire logic [11:0] coreResult,
   output logic [15:0] offsetCal,
   output logic [15:0] gainCal,
   output logic convDone,
   output logic [23:0] dmaAddr,
   output logic [7:0] dmaData,
   output logic dmaWr
);
`include "sac_defs.svh"
   logic [7:0] adcControlOne_r;
   logic [7:0] adcControlTwo_r;
   logic [7:0] adcControlThree_r;
   logic [7:0] resultHigh_r;
   logic [7:0] resultLow_r;
   logic [23:0] dmaPtr_r;
   logic [15:0] offset_r;
   logic [15:0] gain_r;
   sac_state_t state_r;
   logic [5:0] divCnt_r;
   logic [4:0] bitCnt_r;
   logic [1:0] calIdx_r;
   logic pinPrev_r;
   logic tick;
   logic pinFall;
   logic hwTrig;
   logic swStart;
   logic [7:0] rdMux;
   sac_cal_if cal();

   sac_cal_rom u_rom (
      .sys_clk(sys_clk),
      .cal(cal)
   );

   // Divider ratio from the two clock-select bits
   function automatic logic [5:0] divRatio(input logic [1:0] sel);
      unique case (sel)
         2'b00: divRatio = `SAC_DIV_CODE0;
         2'b01: divRatio = `SAC_DIV_CODE1;
         2'b10: divRatio = `SAC_DIV_CODE2;
         2'b11: divRatio = `SAC_DIV_CODE3;
      endcase
   endfunction : divRatio

   assign converterPowerOn = adcControlOne_r[`SAC_BIT_PWR];
   assign outsideReferenceSelect = adcControlOne_r[`SAC_BIT_EXTREF];
   assign channelSel = adcControlTwo_r[`SAC_CHAN_HI:`SAC_CHAN_LO];
   assign offsetCal = offset_r;
   assign gainCal = gain_r;
   assign dmaAddr = dmaPtr_r;
   assign sampleHold = (state_r == SAC_CONV);
   assign cal.addr = calIdx_r;
   assign pinFall = pinPrev_r & ~convertStartPin_n;
   assign swStart = sfrWr && sfrAddr == `SAC_CON2_ADDR && sfrWdata[`SAC_BIT_SCONV];
   // Hardware triggers only while powered
   assign hwTrig = converterPowerOn &&
      ((adcControlOne_r[`SAC_BIT_T2C] && timerOverflow) ||
       (adcControlOne_r[`SAC_BIT_EXC] && pinFall));

   // Converter clock tick; software owns the 8.38 MHz ceiling
   always_ff @(posedge sys_clk) begin
      if (rst || state_r == SAC_IDLE || tick)
         divCnt_r <= 6'h01;
      else
         divCnt_r <= divCnt_r + 6'h01;
   end
   assign tick = divCnt_r >= divRatio(adcControlOne_r[`SAC_BIT_CK_HI:`SAC_BIT_CK_LO]);

   // Pin history for falling-edge detect
   always_ff @(posedge sys_clk) begin
      if (rst)
         pinPrev_r <= 1'b1;
      else
         pinPrev_r <= convertStartPin_n;
   end

   // Control one: byte writes only, no bit access path
   always_ff @(posedge sys_clk) begin
      if (rst)
         adcControlOne_r <= `SAC_CON1_RST;
      else if (sfrWr && sfrAddr == `SAC_CON1_ADDR)
         adcControlOne_r <= sfrWdata;
   end

   // Control two: done flag set wins over a clear
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         adcControlTwo_r <= `SAC_CON2_RST;
      end else begin
         // Start acts on the write itself, so the bit reads back as zero
         if (sfrWr && sfrAddr == `SAC_CON2_ADDR)
            adcControlTwo_r <= {sfrWdata[`SAC_BIT_DONE:`SAC_BIT_CONT], 1'b0,
               sfrWdata[`SAC_CHAN_HI:`SAC_CHAN_LO]};
         if (state_r == SAC_DONE)
            adcControlTwo_r[`SAC_BIT_DONE] <= 1'b1;
      end
   end

   // Control three is plain read/write storage; the capture pointer page is DMAP
   always_ff @(posedge sys_clk) begin
      if (rst)
         adcControlThree_r <= `SAC_CON3_RST;
      else if (sfrWr && sfrAddr == `SAC_CON3_ADDR)
         adcControlThree_r <= sfrWdata;
   end

   // Calibration: factory load, then software or hardware may overwrite
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         offset_r <= `SAC_CAL_RST;
         gain_r <= `SAC_CAL_RST;
      end else if (state_r == SAC_CAL) begin
         // Store data lags the word index by one cycle
         if (calIdx_r == `SAC_CAL_GAIN_LOAD)
            gain_r <= cal.rdata;
         else if (calIdx_r == `SAC_CAL_OFS_LOAD)
            offset_r <= cal.rdata;
      end else if (calWr) begin
         if (calSelGain)
            gain_r <= calWdata;
         else
            offset_r <= calWdata;
      end else if (sfrWr) begin
         unique case (sfrAddr)
            `SAC_OFSL_ADDR: offset_r[7:0] <= sfrWdata;
            `SAC_OFSH_ADDR: offset_r[15:8] <= sfrWdata;
            `SAC_GAINL_ADDR: gain_r[7:0] <= sfrWdata;
            `SAC_GAINH_ADDR: gain_r[15:8] <= sfrWdata;
            default: ;
         endcase
      end
   end

   // Calibration word counter
   always_ff @(posedge sys_clk) begin
      if (rst)
         calIdx_r <= 2'h0;
      else if (state_r == SAC_CAL)
         calIdx_r <= calIdx_r + 2'h1;
   end

   // Sequencer: acquire, convert 16 clocks, latch result
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_r <= SAC_CAL;
         bitCnt_r <= 5'h00;
      end else begin
         unique case (state_r)
            SAC_CAL: if (calIdx_r == `SAC_CAL_WORDS) state_r <= SAC_IDLE;
            SAC_IDLE: begin
               bitCnt_r <= 5'h00;
               if (converterPowerOn && (swStart || hwTrig ||
                   adcControlTwo_r[`SAC_BIT_CONT] || adcControlTwo_r[`SAC_BIT_DMA]))
                  state_r <= SAC_ACQ;
            end
            SAC_ACQ: if (tick) begin
               if (bitCnt_r[1:0] == adcControlOne_r[`SAC_BIT_AQ_HI:`SAC_BIT_AQ_LO]) begin
                  bitCnt_r <= 5'h00;
                  state_r <= SAC_CONV;
               end else
                  bitCnt_r <= bitCnt_r + 5'h01;
            end
            SAC_CONV: if (tick) begin
               if (bitCnt_r == `SAC_CONV_CLKS - 5'h01)
                  state_r <= SAC_DONE;
               else
                  bitCnt_r <= bitCnt_r + 5'h01;
            end
            SAC_DONE: state_r <= adcControlTwo_r[`SAC_BIT_DMA] ? SAC_DMA1 : SAC_IDLE;
            SAC_DMA1: state_r <= SAC_DMA2;
            SAC_DMA2: state_r <= SAC_IDLE;
            default: state_r <= SAC_IDLE;
         endcase
      end
   end
   assign convertStrobe = (state_r == SAC_ACQ) && tick &&
      bitCnt_r[1:0] == adcControlOne_r[`SAC_BIT_AQ_HI:`SAC_BIT_AQ_LO];
   assign convDone = (state_r == SAC_DONE);

   // Result pair written together; straight binary passes untouched
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         resultHigh_r <= 8'h00;
         resultLow_r <= 8'h00;
      end else if (state_r == SAC_CONV && tick && bitCnt_r == `SAC_CONV_CLKS - 5'h01) begin
         resultHigh_r <= {channelSel, coreResult[11:8]};
         resultLow_r <= coreResult[7:0];
      end
   end

   // Capture writes high then low byte and advances the pointer
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dmaPtr_r <= 24'h000000;
         dmaData <= 8'h00;
         dmaWr <= 1'b0;
      end else begin
         dmaWr <= 1'b0;
         if (state_r == SAC_DMA1 || state_r == SAC_DMA2) begin
            dmaData <= (state_r == SAC_DMA1) ? resultHigh_r : resultLow_r;
            dmaWr <= 1'b1;
         end
         if (dmaWr)
            dmaPtr_r <= dmaPtr_r + 24'h000001;
         else if (sfrWr) begin
            unique case (sfrAddr)
               `SAC_DMAL_ADDR: dmaPtr_r[7:0] <= sfrWdata;
               `SAC_DMAH_ADDR: dmaPtr_r[15:8] <= sfrWdata;
               `SAC_DMAP_ADDR: dmaPtr_r[23:16] <= sfrWdata;
               default: ;
            endcase
         end
      end
   end

   // Read mux; unmapped reads return zero
   always_comb begin
      unique case (sfrAddr)
         `SAC_CON1_ADDR: rdMux = adcControlOne_r;
         `SAC_CON2_ADDR: rdMux = adcControlTwo_r;
         `SAC_CON3_ADDR: rdMux = adcControlThree_r;
         `SAC_DATAH_ADDR: rdMux = resultHigh_r;
         `SAC_DATAL_ADDR: rdMux = resultLow_r;
         `SAC_DMAL_ADDR: rdMux = dmaPtr_r[7:0];
         `SAC_DMAH_ADDR: rdMux = dmaPtr_r[15:8];
         `SAC_DMAP_ADDR: rdMux = dmaPtr_r[23:16];
         `SAC_OFSL_ADDR: rdMux = offset_r[7:0];
         `SAC_OFSH_ADDR: rdMux = offset_r[15:8];
         `SAC_GAINL_ADDR: rdMux = gain_r[7:0];
         `SAC_GAINH_ADDR: rdMux = gain_r[15:8];
         default: rdMux = 8'h00;
      endcase
   end

   // Registered read data
   always_ff @(posedge sys_clk) begin
      if (rst)
         sfrRdata <= 8'h00;
      else if (sfrRd)
         sfrRdata <= rdMux;
   end
endmodule : sac_ctrl
`default_nettype wire

// [bench/sac_ctrl_properties.sv]
// Port-level checks on the converter control front end
`timescale 1ns/10ps
`default_nettype none
module sac_ctrl_properties (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWr,
   input wire logic [7:0] sfrWdata,
   input wire logic converterPowerOn,
   input wire logic sampleHold,
   input wire logic convertStrobe,
   input wire logic [15:0] offsetCal,
   input wire logic [15:0] gainCal,
   input wire logic convDone,
   input wire logic [23:0] dmaAddr,
   input wire logic dmaWr
);
   logic [1:0] ckSel_r;
   logic [9:0] holdCnt_r;
   logic [23:0] lastAddr_r;
   logic seen_r;
   int divide;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Divide field as last written; only changed while idle
   always_ff @(posedge sys_clk)
      if (rst) ckSel_r <= 2'h0;
      else if (sfrWr && sfrAddr == 8'hef) ckSel_r <= sfrWdata[5:4];
   assign divide = ckSel_r == 2'h0 ? 32 : ckSel_r == 2'h1 ? 4 : ckSel_r == 2'h2 ? 8 : 2;
   // Cycles spent in the hold phase
   always_ff @(posedge sys_clk)
      holdCnt_r <= (rst || !sampleHold) ? 10'h000 : holdCnt_r + 10'h001;
   // Capture pairing; a pointer rewrite must not look like a skip
   always_ff @(posedge sys_clk) begin
      seen_r <= !rst && !sfrWr && (seen_r || dmaWr);
      if (dmaWr) lastAddr_r <= dmaAddr;
   end
   chk_power_bit:
      assert property (sfrWr && sfrAddr == 8'hef |=> converterPowerOn == $past(sfrWdata[7]))
         else $error("power bit");
   chk_power_off:
      assert property (convertStrobe |-> converterPowerOn) else $error("start while off");
   chk_hold_len:
      assert property ($fell(sampleHold) |-> holdCnt_r >= 16 * divide - 1
         && holdCnt_r <= 16 * divide + 1) else $error("conversion length");
   chk_strobe_hold:
      assert property (convertStrobe |=> sampleHold) else $error("no hold after strobe");
   chk_done_after:
      assert property ($fell(sampleHold) |-> ##[0:2] convDone) else $error("late done");
   chk_done_pulse:
      assert property (convDone |=> !convDone) else $error("done too long");
   chk_cal_load:
      assert property ($fell(rst) |-> ##[0:5] offsetCal == 16'h0000 && gainCal == 16'h8000)
         else $error("calibration not loaded");
   chk_dma_step:
      assert property (dmaWr && seen_r |-> dmaAddr == lastAddr_r + 24'h000001)
         else $error("capture address");
endmodule : sac_ctrl_properties
bind sac_ctrl sac_ctrl_properties sac_ctrl_properties_i (.*);
`default_nettype wire

// [bench/sac_core_model.sv]
// Behavioural converter core facing the control front end
`timescale 1ns/10ps
`default_nettype none
module sac_core_model (
   input wire logic sys_clk,
   input wire logic convertStrobe,
   input wire logic sampleHold,
   input wire logic [3:0] channelSel,
   input wire logic [11:0] level,
   output logic [11:0] coreResult
);
   logic [11:0] val_r = 12'h000;
   logic tog_r = 1'b0;
   // Sample the chosen input when the hold begins
   always @(posedge sys_clk) begin
      tog_r <= ~tog_r;
      if (convertStrobe) val_r <= 12'(channelSel * 409) + level;
   end
   // Valid only while held; otherwise it wanders every cycle
   assign coreResult = sampleHold ? val_r : val_r ^ {12{tog_r}};
endmodule : sac_core_model
`default_nettype wire

// [bench/sar_adc_control_front_end_tb.sv]
// Self-checking bench for the converter control front end
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control_front_end_tb;
   logic sys_clk = 1'b0, rst = 1'b1, sfrWr = 1'b0, sfrRd = 1'b0, calWr = 1'b0;
   logic timerOverflow = 1'b0, convertStartPin_n = 1'b1, calSelGain = 1'b0;
   logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata, dmaData;
   logic [15:0] calWdata = 16'h0000, lfsr = 16'ha11d, offsetCal, gainCal;
   logic [11:0] level = 12'h000, coreResult, want;
   logic converterPowerOn, outsideReferenceSelect, sampleHold, convertStrobe, convDone, dmaWr;
   logic [3:0] channelSel;
   logic [23:0] dmaAddr;
   int nErrors = 0, nTests = 0, i, k;
   logic [7:0] expQ[$];
   sac_ctrl sac_ctrl_i (.*);
   sac_core_model sac_core_model_i (.*);
   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;
   function automatic logic [15:0] nextRand(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : nextRand
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      nTests++;
      if (seen !== exp) begin
         nErrors++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   // Inputs move on the falling edge, clear of the sampling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      sfrAddr = a;
      sfrWdata = d;
      sfrWr = 1'b1;
      @(negedge sys_clk);
      sfrWr = 1'b0;
   endtask : wr
   // Read data is registered, so it is taken a cycle after the strobe
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      @(negedge sys_clk);
      sfrAddr = a;
      sfrRd = 1'b1;
      @(negedge sys_clk);
      sfrRd = 1'b0;
      chk(24'(sfrRdata), 24'(e));
   endtask : rc
   task automatic waitDone();
      int j;
      for (j = 0; j < 4000 && convDone !== 1'b1; j++)
         @(negedge sys_clk);
      chk(24'(j < 4000), 24'h1);
   endtask : waitDone
   task automatic res(input logic [3:0] ch);
      want = 12'(ch * 409) + level;
      rc(8'hd9, want[7:0]);
      rc(8'hda, {ch, want[11:8]});
   endtask : res
   // One trigger event, then count completions over a quiet span
   task automatic trig(input logic [7:0] cfg, input logic t, input logic p, input int e);
      int n;
      wr(8'hef, cfg);
      wr(8'hd8, 8'h05);
      timerOverflow = t;
      convertStartPin_n = !p;
      @(negedge sys_clk);
      timerOverflow = 1'b0;
      repeat (2) @(negedge sys_clk);
      convertStartPin_n = 1'b1;
      n = 0;
      repeat (300) begin
         @(negedge sys_clk);
         n += (convDone === 1'b1);
      end
      chk(24'(n), 24'(e));
      if (e) res(4'h5);
      wr(8'hd8, 8'h00);
   endtask : trig
   task automatic testDone();
      $display("comparisons %0d mismatches %0d", nTests, nErrors);
      if (nErrors == 0 && nTests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : testDone
   initial begin
      repeat (12) @(negedge sys_clk);
      rst = 1'b0;
      repeat (6) @(negedge sys_clk);
      rc(8'hef, 8'h40);
      chk(24'(outsideReferenceSelect), 24'h1);
      rc(8'hd8, 8'h00);
      rc(8'hf3, 8'h00);
      rc(8'hf4, 8'h80);
      rc(8'h90, 8'h00);
      $display("reset test done");
      // Nine inputs, random level, divider and acquisition
      for (i = 0; i < 9; i++) begin
         lfsr = nextRand(lfsr);
         level = lfsr[11:0];
         wr(8'hef, {2'b10, lfsr[15:12], 2'b00});
         wr(8'hd8, 8'h10 | 8'(i));
         chk(24'(channelSel), 24'(i));
         chk(24'(outsideReferenceSelect), 24'h0);
         waitDone();
         rc(8'hd8, 8'h80 | 8'(i));
         res(4'(i));
      end
      $display("channel test done");
      trig(8'hb2, 1'b1, 1'b0, 1);
      trig(8'hb1, 1'b0, 1'b1, 1);
      trig(8'hb1, 1'b1, 1'b0, 0);
      trig(8'h03, 1'b1, 1'b1, 0);
      $display("trigger test done");
      wr(8'hef, 8'hbc);
      wr(8'hd8, 8'h32);
      for (i = 0; i < 3; i++) begin
         waitDone();
         res(4'h2);
      end
      wr(8'hd8, 8'h00);
      repeat (100) @(negedge sys_clk);
      $display("continuous test done");
      // Pointer just below a 64k boundary
      wr(8'hd4, 8'h00);
      wr(8'hd3, 8'hff);
      wr(8'hd2, 8'hfe);
      want = 12'(7 * 409) + level;
      // Expected capture bytes, high then low, for two samples
      repeat (2) begin
         expQ.push_back({4'h7, want[11:8]});
         expQ.push_back(want[7:0]);
      end
      wr(8'hd8, 8'h57);
      k = 0;
      for (i = 0; i < 2000 && expQ.size() > 0; i++) begin
         @(negedge sys_clk);
         if (dmaWr === 1'b1) begin
            chk(dmaAddr, 24'h00fffe + 24'(k));
            chk(24'(dmaData), 24'(expQ.pop_front()));
            k++;
         end
      end
      chk(24'(k), 24'h4);
      wr(8'hd8, 8'h00);
      $display("capture test done");
      for (k = 0; k < 2; k++) begin
         lfsr = nextRand(lfsr);
         calWdata = lfsr;
         calSelGain = k[0];
         calWr = 1'b1;
         @(negedge sys_clk);
         calWr = 1'b0;
         chk(k[0] ? 24'(gainCal) : 24'(offsetCal), 24'(lfsr));
         rc(8'hf1 + 8'(2 * k), lfsr[7:0]);
         rc(8'hf2 + 8'(2 * k), lfsr[15:8]);
      end
      $display("calibration test done");
      testDone();
   end
   // Watchdog well past the expected run length
   initial begin
      repeat (60000) @(posedge sys_clk);
      nErrors++;
      testDone();
   end
endmodule : sar_adc_control_front_end_tb
`default_nettype wire
